// ---- flag_bank.sv ----
// sticky flag bank: per-bit set and clear, set wins over clear
`timescale 1ns/1ps
`default_nettype none
module flag_bank #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output var  logic [W-1:0] q
);
    logic [W-1:0] q_ff;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge core_clk)
            begin
                if (srst)
                    q_ff[i] <= 1'b0;
                else
                    q_ff[i] <= set[i] | (q_ff[i] & ~clr[i]);
            end
        end
    endgenerate

    assign q = q_ff;
endmodule
`default_nettype wire

// ---- rx_port_interrupt_logic.sv ----
// receive port interrupt enables, sticky status and read-to-clear logic on avalon-mm
// Function
// - line length change raises interrupt when its enable bit set
// - lines-per-frame change raises interrupt when its enable bit set
// - receive buffer overflow raises interrupt when its enable bit set
// - csi receiver error raises interrupt when its enable bit set
// - link parity error raises interrupt when its enable bit set
// - port valid change, either direction, raises interrupt when enabled
// - lock status change raises interrupt when its enable bit set
// - gpio change flag set on event, cleared by reading gpio status
// - sensor flag cleared only after both rise and fall registers read
// - encoding error flag cleared by reading second port status register
// - sequence error flag cleared by reading first port status register
// - control channel crc flag cleared by reading first status register
// - line length flag cleared by reading second port status register
// - line count flag cleared by reading second port status register
// - buffer overflow flag cleared by reading second port status register
// - csi error flag cleared by reading csi receiver status register
// - parity error flag cleared by reading first port status register
// - port valid flag cleared by reading first port status register
// - lock flag cleared by reading first port status register
// - upper enable register holds encoding, sequence, crc enables, reset zero
// - per-gpio interrupt status bits clear when gpio status read
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rx_port_interrupt_logic #(
    parameter int LEN_W = rx_port_irq_pkg::LEN_W,
    parameter int CNT_W = rx_port_irq_pkg::CNT_W
) (
    input  wire logic                                core_clk,
    input  wire logic                                srst,
    input  wire logic [rx_port_irq_pkg::ADDR_W-1:0]  avs_address,
    input  wire logic                                avs_read,
    input  wire logic                                avs_write,
    input  wire logic [rx_port_irq_pkg::DATA_W-1:0]  avs_writedata,
    input  wire logic [3:0]                          avs_byteenable,
    output var  logic [rx_port_irq_pkg::DATA_W-1:0]  avs_readdata,
    output var  logic                                avs_waitrequest,
    input  wire rx_port_irq_pkg::port_events_t       ev,
    input  wire rx_port_irq_pkg::src_status_t        src,
    output var  logic                                irq,
    output var  logic                                clr_rx_status_first,
    output var  logic                                clr_rx_status_second,
    output var  logic                                clr_csi_status
);
    localparam int LO_N = rx_port_irq_pkg::LO_N;
    localparam int HI_N = rx_port_irq_pkg::HI_N;
    localparam int GN   = rx_port_irq_pkg::GPIO_N;
    localparam int SN   = rx_port_irq_pkg::SENS_N;

    // bus handshake
    logic        ack_ff;
    logic        req;
    logic        capture;
    logic        rd_acc;
    logic        wr_acc;
    logic [7:0]  idx;
    logic        aligned;
    logic [rx_port_irq_pkg::DATA_W-1:0] readdata_ff;
    logic [rx_port_irq_pkg::DATA_W-1:0] nxt_readdata;

    // registers and flags
    logic [7:0]                         en_lo_ff;
    logic [rx_port_irq_pkg::EN_HI_N-1:0] en_hi_ff;
    logic [LO_N-1:0] st_lo;
    logic [HI_N-1:0] st_hi;
    logic [LO_N-1:0] set_lo;
    logic [LO_N-1:0] clr_lo;
    logic [HI_N-1:0] set_hi;
    logic [HI_N-1:0] clr_hi;
    logic [LO_N-1:0] snap_lo_ff;
    logic [HI_N-1:0] snap_hi_ff;
    logic [GN-1:0]   gpio_int;
    logic [GN-1:0]   gpio_clr;
    logic [SN-1:0]   rise_q;
    logic [SN-1:0]   fall_q;
    logic [SN-1:0]   rise_clr;
    logic [SN-1:0]   fall_clr;
    logic [GN-1:0]   snap_gpio_ff;
    logic [SN-1:0]   snap_rise_ff;
    logic [SN-1:0]   snap_fall_ff;
    logic            rise_seen_ff;
    logic            fall_seen_ff;
    logic            sens_done;

    // change detectors
    logic             primed_ff;
    logic             pass_ff;
    logic             lock_ff;
    logic [LEN_W-1:0] len_ff;
    logic             len_valid_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             cnt_valid_ff;
    logic             len_chg;
    logic             cnt_chg;
    logic             pass_chg;
    logic             lock_chg;

    logic irq_ff;
    logic clr_first_ff;
    logic clr_second_ff;
    logic clr_csi_ff;

    logic rd_first;
    logic rd_second;
    logic rd_csi;
    logic rd_gpio;
    logic rd_rise;
    logic rd_fall;

    // one wait cycle per access: data captured at first edge, taken at second
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_ff;
    assign capture         = avs_read & ~ack_ff;
    assign rd_acc          = avs_read & ack_ff;
    assign wr_acc          = avs_write & ack_ff & avs_byteenable[0];
    assign aligned         = (avs_address[1:0] == 2'h0);
    assign idx             = avs_address[9:2];

    always_ff @(posedge core_clk)
    begin
        if (srst)
            ack_ff <= 1'b0;
        else
            ack_ff <= req & ~ack_ff;
    end

    assign rd_first  = rd_acc & aligned & (idx == rx_port_irq_pkg::IDX_RX_STS_1);
    assign rd_second = rd_acc & aligned & (idx == rx_port_irq_pkg::IDX_RX_STS_2);
    assign rd_csi    = rd_acc & aligned & (idx == rx_port_irq_pkg::IDX_CSI_STATUS);
    assign rd_gpio   = rd_acc & aligned & (idx == rx_port_irq_pkg::IDX_FWD_GPIO);
    assign rd_rise   = rd_acc & aligned & (idx == rx_port_irq_pkg::IDX_SENS_RISE);
    assign rd_fall   = rd_acc & aligned & (idx == rx_port_irq_pkg::IDX_SENS_FALL);

    always_comb
    begin
        nxt_readdata = '0;
        if (aligned)
        begin
            unique case (idx)
                rx_port_irq_pkg::IDX_EN_LOW:
                    nxt_readdata[7:0] = en_lo_ff;
                rx_port_irq_pkg::IDX_EN_HIGH:
                    nxt_readdata[2:0] = en_hi_ff;
                rx_port_irq_pkg::IDX_ST_LOW:
                    nxt_readdata[LO_N-1:0] = st_lo;
                rx_port_irq_pkg::IDX_ST_HIGH:
                    nxt_readdata[HI_N-1:0] = st_hi;
                rx_port_irq_pkg::IDX_FWD_GPIO:
                    nxt_readdata[7:0] = {gpio_int, ev.gpio_level};
                rx_port_irq_pkg::IDX_SENS_RISE:
                    nxt_readdata[7:0] = rise_q;
                rx_port_irq_pkg::IDX_SENS_FALL:
                    nxt_readdata[7:0] = fall_q;
                rx_port_irq_pkg::IDX_RX_STS_1:
                    nxt_readdata[7:0] = src.rx_port_status_first;
                rx_port_irq_pkg::IDX_RX_STS_2:
                    nxt_readdata[7:0] = src.rx_port_status_second;
                rx_port_irq_pkg::IDX_CSI_STATUS:
                    nxt_readdata[7:0] = src.csi_receiver_status;
                default:
                    nxt_readdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            readdata_ff <= '0;
        else if (capture)
            readdata_ff <= nxt_readdata;
    end

    assign avs_readdata = readdata_ff;

    // flags seen at capture are the only ones a read may clear, so a late event survives
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            snap_lo_ff   <= '0;
            snap_hi_ff   <= '0;
            snap_gpio_ff <= '0;
            snap_rise_ff <= '0;
            snap_fall_ff <= '0;
        end
        else if (capture)
        begin
            snap_lo_ff   <= st_lo;
            snap_hi_ff   <= st_hi;
            snap_gpio_ff <= gpio_int;
            snap_rise_ff <= rise_q;
            snap_fall_ff <= fall_q;
        end
    end

    // enable registers
    always_ff @(posedge core_clk)
    begin
        if (srst)
            en_lo_ff <= rx_port_irq_pkg::EN_LO_RST;
        else if (wr_acc && aligned && idx == rx_port_irq_pkg::IDX_EN_LOW)
            en_lo_ff <= avs_writedata[7:0];
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
            en_hi_ff <= rx_port_irq_pkg::EN_HI_RST;
        else if (wr_acc && aligned && idx == rx_port_irq_pkg::IDX_EN_HIGH)
            en_hi_ff <= avs_writedata[2:0];
    end

    // change detection; first sample after reset only primes the history
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            primed_ff <= 1'b0;
            pass_ff   <= 1'b0;
            lock_ff   <= 1'b0;
        end
        else
        begin
            primed_ff <= 1'b1;
            pass_ff   <= ev.port_pass;
            lock_ff   <= ev.lock;
        end
    end

    assign pass_chg = primed_ff & (ev.port_pass ^ pass_ff);
    assign lock_chg = primed_ff & (ev.lock ^ lock_ff);

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            len_ff       <= '0;
            len_valid_ff <= 1'b0;
        end
        else if (ev.line_end)
        begin
            len_ff       <= ev.line_len;
            len_valid_ff <= 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            cnt_ff       <= '0;
            cnt_valid_ff <= 1'b0;
        end
        else if (ev.frame_end)
        begin
            cnt_ff       <= ev.line_cnt;
            cnt_valid_ff <= 1'b1;
        end
    end

    assign len_chg = ev.line_end & len_valid_ff & (ev.line_len != len_ff);
    assign cnt_chg = ev.frame_end & cnt_valid_ff & (ev.line_cnt != cnt_ff);

    // status set sources; status latches regardless of enable, enable gates irq only
    always_comb
    begin
        set_lo                              = '0;
        set_lo[rx_port_irq_pkg::B_LOCK]     = lock_chg;
        set_lo[rx_port_irq_pkg::B_PASS]     = pass_chg;
        set_lo[rx_port_irq_pkg::B_PARITY]   = ev.parity_err;
        set_lo[rx_port_irq_pkg::B_CSI]      = ev.csi_err;
        set_lo[rx_port_irq_pkg::B_BUF]      = ev.buf_ovf;
        set_lo[rx_port_irq_pkg::B_LINE_CNT] = cnt_chg;
        set_lo[rx_port_irq_pkg::B_LINE_LEN] = len_chg;
    end

    always_comb
    begin
        clr_lo                              = '0;
        clr_lo[rx_port_irq_pkg::B_LOCK]     = rd_first;
        clr_lo[rx_port_irq_pkg::B_PASS]     = rd_first;
        clr_lo[rx_port_irq_pkg::B_PARITY]   = rd_first;
        clr_lo[rx_port_irq_pkg::B_CSI]      = rd_csi;
        clr_lo[rx_port_irq_pkg::B_BUF]      = rd_second;
        clr_lo[rx_port_irq_pkg::B_LINE_CNT] = rd_second;
        clr_lo[rx_port_irq_pkg::B_LINE_LEN] = rd_second;
        clr_lo                              = clr_lo & snap_lo_ff;
    end

    // sensor flag needs both edge registers read; the order does not matter
    assign sens_done = (rd_rise & (fall_seen_ff | rd_fall)) | (rd_fall & rise_seen_ff);

    always_ff @(posedge core_clk)
    begin
        if (srst || sens_done)
        begin
            rise_seen_ff <= 1'b0;
            fall_seen_ff <= 1'b0;
        end
        else
        begin
            rise_seen_ff <= rise_seen_ff | rd_rise;
            fall_seen_ff <= fall_seen_ff | rd_fall;
        end
    end

    always_comb
    begin
        set_hi                          = '0;
        set_hi[rx_port_irq_pkg::B_CRC]  = ev.crc_err;
        set_hi[rx_port_irq_pkg::B_SEQ]  = ev.seq_err;
        set_hi[rx_port_irq_pkg::B_ENC]  = ev.enc_err;
        set_hi[rx_port_irq_pkg::B_SENS] = |ev.sens_rise | |ev.sens_fall;
        set_hi[rx_port_irq_pkg::B_GPIO] = |ev.gpio_event;
    end

    always_comb
    begin
        clr_hi                          = '0;
        clr_hi[rx_port_irq_pkg::B_CRC]  = rd_first;
        clr_hi[rx_port_irq_pkg::B_SEQ]  = rd_first;
        clr_hi[rx_port_irq_pkg::B_ENC]  = rd_second;
        clr_hi[rx_port_irq_pkg::B_SENS] = sens_done;
        clr_hi[rx_port_irq_pkg::B_GPIO] = rd_gpio;
        clr_hi                          = clr_hi & snap_hi_ff;
    end

    assign gpio_clr = {GN{rd_gpio}} & snap_gpio_ff;
    assign rise_clr = {SN{rd_rise}} & snap_rise_ff;
    assign fall_clr = {SN{rd_fall}} & snap_fall_ff;

    flag_bank #(.W(LO_N)) u_st_lo (
        .core_clk (core_clk),
        .srst     (srst),
        .set      (set_lo),
        .clr      (clr_lo),
        .q        (st_lo)
    );

    flag_bank #(.W(HI_N)) u_st_hi (
        .core_clk (core_clk),
        .srst     (srst),
        .set      (set_hi),
        .clr      (clr_hi),
        .q        (st_hi)
    );

    flag_bank #(.W(GN)) u_gpio (
        .core_clk (core_clk),
        .srst     (srst),
        .set      (ev.gpio_event),
        .clr      (gpio_clr),
        .q        (gpio_int)
    );

    flag_bank #(.W(SN)) u_rise (
        .core_clk (core_clk),
        .srst     (srst),
        .set      (ev.sens_rise),
        .clr      (rise_clr),
        .q        (rise_q)
    );

    flag_bank #(.W(SN)) u_fall (
        .core_clk (core_clk),
        .srst     (srst),
        .set      (ev.sens_fall),
        .clr      (fall_clr),
        .q        (fall_q)
    );

    // gpio and sensor flags drive irq directly; no enable register gates them
    always_ff @(posedge core_clk)
    begin
        if (srst)
            irq_ff <= 1'b0;
        else
            irq_ff <= (|(st_lo & en_lo_ff[LO_N-1:0]))
                    | (|(st_hi[2:0] & en_hi_ff))
                    | st_hi[rx_port_irq_pkg::B_SENS]
                    | st_hi[rx_port_irq_pkg::B_GPIO];
    end

    assign irq = irq_ff;

    // read notices to the owners of the source status registers
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            clr_first_ff  <= 1'b0;
            clr_second_ff <= 1'b0;
            clr_csi_ff    <= 1'b0;
        end
        else
        begin
            clr_first_ff  <= rd_first;
            clr_second_ff <= rd_second;
            clr_csi_ff    <= rd_csi;
        end
    end

    assign clr_rx_status_first  = clr_first_ff;
    assign clr_rx_status_second = clr_second_ff;
    assign clr_csi_status       = clr_csi_ff;

endmodule
`default_nettype wire

// ---- rx_port_irq_chk.sv ----
// concurrent checks on the bus answer, clear pulses and irq of the port interrupt block
`timescale 1ns/1ps
`default_nettype none
module rx_port_irq_chk (
    input wire logic                               core_clk,
    input wire logic                               srst,
    input wire logic [rx_port_irq_pkg::ADDR_W-1:0] avs_address,
    input wire logic                               avs_read,
    input wire logic                               avs_write,
    input wire logic [rx_port_irq_pkg::DATA_W-1:0] avs_readdata,
    input wire logic                               avs_waitrequest,
    input wire rx_port_irq_pkg::port_events_t      ev,
    input wire rx_port_irq_pkg::src_status_t       src,
    input wire logic                               irq,
    input wire logic                               clr_rx_status_first,
    input wire logic                               clr_rx_status_second,
    input wire logic                               clr_csi_status
);
    localparam logic [9:0] A_FIRST  = {rx_port_irq_pkg::IDX_RX_STS_1, 2'b00};
    localparam logic [9:0] A_SECOND = {rx_port_irq_pkg::IDX_RX_STS_2, 2'b00};
    localparam logic [9:0] A_CSI    = {rx_port_irq_pkg::IDX_CSI_STATUS, 2'b00};

    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence rd_acc(logic [9:0] a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    // flag lands one edge after the pulse, irq one edge after the flag
    sequence irq_late;
        ##1 irq;
    endsequence

    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high with no request");
    clr_first_a:
        assert property (rd_acc(A_FIRST) |=> clr_rx_status_first)
        else $error("first status read gave no clear pulse");
    clr_second_a:
        assert property (rd_acc(A_SECOND) |=> clr_rx_status_second)
        else $error("second status read gave no clear pulse");
    clr_csi_a:
        assert property (rd_acc(A_CSI) |=> clr_csi_status ##1 !clr_csi_status)
        else $error("csi status read gave a wrong clear pulse");
    clr_cause_a:
        assert property (clr_rx_status_first |-> $past(avs_read && !avs_waitrequest
            && avs_address == A_FIRST))
        else $error("first clear pulse without an accepted read");
    gpio_irq_a:
        assert property (ev.gpio_event != 4'h0 |=> irq_late)
        else $error("gpio event did not raise irq");
    // src is held steady by the bench, so the past sample is the captured one
    first_thru_a: assert property (rd_acc(A_FIRST) |-> avs_readdata == {24'h0,
            $past(src.rx_port_status_first)})
        else $error("first status read data wrong");
    rst_quiet_a:
        assert property (disable iff (1'b0) srst |=> !irq && !clr_rx_status_first)
        else $error("irq or clear pulse after reset");
endmodule
`default_nettype wire

// ---- rx_port_irq_pkg.sv ----
// package: register map, field positions, reset values and carrier types for the port interrupts
package rx_port_irq_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int LEN_W  = 16;
    localparam int CNT_W  = 16;
    localparam int GPIO_N = 4;
    localparam int SENS_N = 8;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CSI_STATUS  = 8'h7A;
    localparam logic [7:0] IDX_EN_HIGH     = 8'hD8;
    localparam logic [7:0] IDX_EN_LOW      = 8'hD9;
    localparam logic [7:0] IDX_ST_HIGH     = 8'hDA;
    localparam logic [7:0] IDX_ST_LOW      = 8'hDB;
    localparam logic [7:0] IDX_FWD_GPIO    = 8'hDC;
    localparam logic [7:0] IDX_SENS_RISE   = 8'hDE;
    localparam logic [7:0] IDX_SENS_FALL   = 8'hDF;
    localparam logic [7:0] IDX_RX_STS_1    = 8'hE0;
    localparam logic [7:0] IDX_RX_STS_2    = 8'hE1;

    // low status / low enable bit positions
    localparam int B_LOCK     = 0;
    localparam int B_PASS     = 1;
    localparam int B_PARITY   = 2;
    localparam int B_CSI      = 3;
    localparam int B_BUF      = 4;
    localparam int B_LINE_CNT = 5;
    localparam int B_LINE_LEN = 6;
    localparam int LO_N       = 7;

    // high status / high enable bit positions
    localparam int B_CRC      = 0;
    localparam int B_SEQ      = 1;
    localparam int B_ENC      = 2;
    localparam int B_SENS     = 3;
    localparam int B_GPIO     = 4;
    localparam int HI_N       = 5;
    localparam int EN_HI_N    = 3;

    localparam logic [7:0]         EN_LO_RST = 8'h00;
    localparam logic [EN_HI_N-1:0] EN_HI_RST = 3'h0;

    typedef struct packed {
        logic                line_end;
        logic [LEN_W-1:0]    line_len;
        logic                frame_end;
        logic [CNT_W-1:0]    line_cnt;
        logic                buf_ovf;
        logic                csi_err;
        logic                parity_err;
        logic                port_pass;
        logic                lock;
        logic                enc_err;
        logic                seq_err;
        logic                crc_err;
        logic [GPIO_N-1:0]   gpio_level;
        logic [GPIO_N-1:0]   gpio_event;
        logic [SENS_N-1:0]   sens_rise;
        logic [SENS_N-1:0]   sens_fall;
    } port_events_t;

    typedef struct packed {
        logic [7:0] rx_port_status_first;
        logic [7:0] rx_port_status_second;
        logic [7:0] csi_receiver_status;
    } src_status_t;

endpackage

// ---- test_rx_port_interrupt_logic.sv ----
// self-checking bench for the port interrupt block over avalon-mm
`timescale 1ns/1ps
`default_nettype none
module test_rx_port_interrupt_logic;
    localparam logic [7:0] EN_LO  = rx_port_irq_pkg::IDX_EN_LOW;
    localparam logic [7:0] EN_HI  = rx_port_irq_pkg::IDX_EN_HIGH;
    localparam logic [7:0] ST_LO  = rx_port_irq_pkg::IDX_ST_LOW;
    localparam logic [7:0] ST_HI  = rx_port_irq_pkg::IDX_ST_HIGH;
    localparam logic [7:0] FIRST  = rx_port_irq_pkg::IDX_RX_STS_1;
    localparam logic [7:0] SECOND = rx_port_irq_pkg::IDX_RX_STS_2;
    localparam logic [7:0] CSI    = rx_port_irq_pkg::IDX_CSI_STATUS;
    logic                          core_clk;
    logic                          srst;
    logic [9:0]                    avs_address;
    logic                          avs_read;
    logic                          avs_write;
    logic [31:0]                   avs_writedata;
    logic [3:0]                    avs_byteenable;
    logic [31:0]                   avs_readdata;
    logic                          avs_waitrequest;
    rx_port_irq_pkg::port_events_t ev;
    rx_port_irq_pkg::port_events_t m;
    rx_port_irq_pkg::src_status_t  src;
    logic                          irq;
    logic                          clr_first;
    logic                          clr_second;
    logic                          clr_csi;
    logic [31:0]                   rd_v;
    logic [7:0]                    clr_tab [10];
    logic [7:0]                    bit_v;
    logic [7:0]                    sta;
    logic [7:0]                    en;
    int                            error_cnt;
    int                            total_checks;

    rx_port_interrupt_logic dut (
        .core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ev(ev), .src(src),
        .irq(irq), .clr_rx_status_first(clr_first), .clr_rx_status_second(clr_second),
        .clr_csi_status(clr_csi)
    );

    always #4 core_clk = ~core_clk;

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // sampled mid-cycle so the registered irq of the last edge has landed
    task automatic chk_irq(input logic exp);
        @(negedge core_clk);
        total_checks++;
        if (irq !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: irq %b expected %b", $time, irq, exp);
        end
        @(posedge core_clk);
    endtask

    // one access; the trailing edge keeps a released request from rising in the same step
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, wd};
        avs_read <= !wr;
        avs_write <= wr;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0)
        begin
            error_cnt++;
            $display("mismatch at %0t: access never answered", $time);
            close_out();
        end
        rd_v = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd_v, {24'h0, exp});
    endtask

    task automatic flip(input rx_port_irq_pkg::port_events_t f);
        ev <= ev ^ f;
        @(posedge core_clk);
    endtask

    task automatic cause(input int j);
        m = '0;
        case (j)
            0: m.lock = 1'b1;
            1: m.port_pass = 1'b1;
            2: m.parity_err = 1'b1;
            3: m.csi_err = 1'b1;
            4: m.buf_ovf = 1'b1;
            5: {m.frame_end, m.line_cnt} = {1'b1, 16'h0001};
            6: {m.line_end, m.line_len} = {1'b1, 16'h0004};
            7: m.crc_err = 1'b1;
            8: m.seq_err = 1'b1;
            default: m.enc_err = 1'b1;
        endcase
        flip(m);
        if (j > 1)
            flip(m);
    endtask

    initial
    begin
        core_clk = 1'b0;
        srst = 1'b1;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        ev = '0;
        src = {8'hA5, 8'h5A, 8'hC3};
        error_cnt = 0;
        total_checks = 0;
        clr_tab = '{FIRST, FIRST, FIRST, CSI, SECOND, SECOND, SECOND, FIRST, FIRST, SECOND};
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        repeat (2) @(posedge core_clk);
        rd(EN_LO, 8'h00);
        rd(EN_HI, 8'h00);
        rd(ST_HI, 8'h00);
        rd(ST_LO, 8'h00);
        wr_check: begin
            bus(1'b1, EN_LO, 8'hFF);
            rd(EN_LO, 8'hFF);
            bus(1'b1, EN_HI, 8'hFF);
            rd(EN_HI, 8'h07);
            bus(1'b1, ST_LO, 8'hFF);
            rd(ST_LO, 8'h00);
            avs_byteenable <= 4'hE;
            bus(1'b1, EN_LO, 8'h00);
            avs_byteenable <= 4'hF;
            rd(EN_LO, 8'hFF);
            rd(8'h00, 8'h00);
            bus(1'b1, EN_LO, 8'h00);
            bus(1'b1, EN_HI, 8'h00);
        end
        // first line and frame samples after reset only prime the history
        m = '0;
        {m.line_end, m.frame_end} = 2'b11;
        flip(m);
        flip(m);
        rd(ST_LO, 8'h00);
        for (int j = 0; j < 10; j++)
        begin
            bit_v = 8'h01 << (j > 6 ? j - 7 : j);
            sta = j > 6 ? ST_HI : ST_LO;
            en = j > 6 ? EN_HI : EN_LO;
            cause(j);
            rd(sta, bit_v);
            chk_irq(1'b0);
            bus(1'b1, en, bit_v);
            chk_irq(1'b1);
            bus(1'b0, clr_tab[j] == FIRST ? SECOND : FIRST, 8'h00);
            rd(sta, bit_v);
            rd(clr_tab[j],
                clr_tab[j] == FIRST ? 8'hA5 : clr_tab[j] == SECOND ? 8'h5A : 8'hC3);
            rd(sta, 8'h00);
            chk_irq(1'b0);
            bus(1'b1, en, 8'h00);
        end
        m = '0;
        {m.gpio_level, m.gpio_event} = 8'h54;
        flip(m);
        m.gpio_level = 4'h0;
        flip(m);
        rd(ST_HI, 8'h10);
        chk_irq(1'b1);
        rd(rx_port_irq_pkg::IDX_FWD_GPIO, 8'h45);
        rd(rx_port_irq_pkg::IDX_FWD_GPIO, 8'h05);
        rd(ST_HI, 8'h00);
        chk_irq(1'b0);
        m = '0;
        {m.sens_rise, m.sens_fall} = 16'h0240;
        flip(m);
        flip(m);
        rd(ST_HI, 8'h08);
        rd(rx_port_irq_pkg::IDX_SENS_FALL, 8'h40);
        rd(ST_HI, 8'h08);
        rd(rx_port_irq_pkg::IDX_SENS_RISE, 8'h02);
        rd(ST_HI, 8'h00);
        bus(1'b1, EN_LO, 8'h01);
        cause(0);
        // the flag lands at the edge that ends cause, irq one edge later
        @(posedge core_clk);
        chk_irq(1'b1);
        srst <= 1'b1;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk_irq(1'b0);
        rd(EN_LO, 8'h00);
        rd(ST_LO, 8'h00);
        close_out();
    end
endmodule

bind rx_port_interrupt_logic rx_port_irq_chk chk (
    .core_clk(core_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ev(ev), .src(src), .irq(irq), .clr_rx_status_first(clr_rx_status_first),
    .clr_rx_status_second(clr_rx_status_second), .clr_csi_status(clr_csi_status)
);
`default_nettype wire
